/* pkg/lvdc_pkg.sv */
package lvdc_pkg;
    // APB register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_MON = 8'h10;

    // Control register field positions.
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_EXT_BIT = 2;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_MASK_BIT = 0;

    // Status and mask register bit positions.
    localparam int ST_DETECT_BIT = 0;
    localparam int ST_RESET_BIT = 1;

    // Values after reset.
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [3:0] LEVEL_RST = 4'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Level-selection width and the fixed code used for the external sense input.
    localparam int LEVEL_W = 4;
    localparam logic [3:0] EXT_FIXED_LEVEL = 4'hf;

    // Enable sequence settling time and cycle count at 200 MHz.
    localparam int SETTLE_NS = 20;
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W = 3;

    // Sequencer states.
    typedef enum logic [1:0] {LVDC_OFF, LVDC_SETTLE, LVDC_RUN} lvdc_state_t;
endpackage : lvdc_pkg

/* design/lvdc_edge.sv */
`timescale 1ns/1ps
// Registers the comparator output and reports its rising edge.
module lvdc_edge (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Level in, edge out
    input wire logic level_in,
    output logic level_q_o,
    output logic rise_o
);
    typedef struct packed {
        logic lvl;
    } lvdc_edge_st_t;

    lvdc_edge_st_t st_q;
    lvdc_edge_st_t st_d;

    // Next state is the current level.
    always_comb begin
        st_d = st_q;
        st_d.lvl = level_in;
    end

    // Register the level.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_q_o = st_q.lvl;
    assign rise_o = level_in & ~st_q.lvl;
endmodule : lvdc_edge

/* design/lvdc_top.sv */
`timescale 1ns/1ps
// Behaviour
// - Interrupt mode: clearing enable while below threshold sets flag and, if unmasked, raises request.
// - External sense source uses one fixed threshold, ignoring level-select.
// - Setting reset mode while voltage is above threshold gives no reset.
// - Unmasked interrupt may fire right after enabling if already low.
// - No hysteresis: each new crossing repeats reset or interrupt.
module lvdc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator side
    input wire logic below_threshold,
    output logic cmp_enable,
    output logic ext_sense_sel,
    output logic [3:0] cmp_level,
    // Events
    output logic lowvolt_irq_request,
    output logic internal_reset_req,
    output logic irq
);
    typedef struct packed {
        lvdc_pkg::lvdc_state_t state;
        logic [2:0] settle;
        logic detector_enable;
        logic ext_src;
        logic reset_mode_select;
        logic lowvolt_irq_mask;
        logic [3:0] level_select_reg;
        logic [1:0] status;
        logic [1:0] irq_en;
        logic lowvolt_irq_flag;
        logic irq_pulse;
        logic rst_out;
        logic [31:0] rdata;
    } lvdc_st_t;

    lvdc_st_t st_q;
    lvdc_st_t st_d;
    logic below_q;
    logic below_rise;
    logic access;
    logic wr;
    logic running;
    logic detect_ev;
    logic stop_low_ev;

    // Comparator sampling; a fresh edge is needed for each new event.
    lvdc_edge u_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .level_in(below_threshold),
        .level_q_o(below_q),
        .rise_o(below_rise)
    );

    // Zero-wait APB: every access completes in its first access cycle.
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign running = (st_q.state == lvdc_pkg::LVDC_RUN);
    // A detection is a new crossing below threshold while running; entry into run while low is caught by the sequencer.
    assign detect_ev = running & below_rise;
    // Clearing enable in interrupt mode while low still reports the event.
    // The live comparator level is used, so a crossing in the stopping cycle itself is not lost.
    assign stop_low_ev = wr & (paddr == lvdc_pkg::ADDR_CTRL) & st_q.detector_enable
                         & ~pwdata[lvdc_pkg::CTRL_EN_BIT] & ~st_q.reset_mode_select & below_threshold;

    // Next-state logic for sequencer, registers and events.
    always_comb begin
        logic ev_irq;
        logic ev_rst;
        logic entered;
        ev_irq = 1'b0;
        ev_rst = 1'b0;
        entered = 1'b0;
        st_d = st_q;
        st_d.irq_pulse = 1'b0;
        st_d.rst_out = 1'b0;

        // Sequencer: settle after enable before comparator output is trusted.
        case (st_q.state)
            lvdc_pkg::LVDC_OFF: begin
                if (st_q.detector_enable) begin
                    st_d.state = lvdc_pkg::LVDC_SETTLE;
                    st_d.settle = 3'(lvdc_pkg::SETTLE_CYC - 1);
                end
            end
            lvdc_pkg::LVDC_SETTLE: begin
                if (!st_q.detector_enable) begin
                    st_d.state = lvdc_pkg::LVDC_OFF;
                end else if (st_q.settle == 3'h0) begin
                    st_d.state = lvdc_pkg::LVDC_RUN;
                    entered = below_q;
                end else begin
                    st_d.settle = st_q.settle - 3'h1;
                end
            end
            lvdc_pkg::LVDC_RUN: begin
                if (!st_q.detector_enable) begin
                    st_d.state = lvdc_pkg::LVDC_OFF;
                end
            end
            default: begin
                st_d.state = lvdc_pkg::LVDC_OFF;
            end
        endcase

        // Mode bit picks the outcome; reset only on an actual low, never on the mode write itself.
        if (detect_ev | entered) begin
            if (st_q.reset_mode_select) begin
                ev_rst = 1'b1;
            end else begin
                ev_irq = 1'b1;
            end
        end
        if (stop_low_ev) begin
            ev_irq = 1'b1;
        end

        // Interrupt request and flag; the mask gates the request only.
        if (ev_irq) begin
            st_d.lowvolt_irq_flag = 1'b1;
            st_d.irq_pulse = ~st_q.lowvolt_irq_mask;
        end
        st_d.rst_out = ev_rst;

        // Register writes; reads are registered on the setup cycle.
        st_d.rdata = 32'h0000_0000;
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                lvdc_pkg::ADDR_CTRL: begin
                    st_d.rdata[lvdc_pkg::CTRL_EN_BIT] = st_q.detector_enable;
                    st_d.rdata[lvdc_pkg::CTRL_EXT_BIT] = st_q.ext_src;
                    st_d.rdata[lvdc_pkg::CTRL_MODE_BIT] = st_q.reset_mode_select;
                    st_d.rdata[lvdc_pkg::CTRL_MASK_BIT] = st_q.lowvolt_irq_mask;
                end
                lvdc_pkg::ADDR_LEVEL: st_d.rdata[3:0] = st_q.level_select_reg;
                lvdc_pkg::ADDR_STATUS: st_d.rdata[1:0] = st_q.status;
                lvdc_pkg::ADDR_MASK: st_d.rdata[1:0] = st_q.irq_en;
                lvdc_pkg::ADDR_MON: begin
                    st_d.rdata[0] = below_q;
                    st_d.rdata[1] = st_q.lowvolt_irq_flag;
                    st_d.rdata[3:2] = st_q.state;
                end
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (paddr)
                lvdc_pkg::ADDR_CTRL: begin
                    // Writing zero or clearing only enable both stop the detector.
                    st_d.detector_enable = pwdata[lvdc_pkg::CTRL_EN_BIT];
                    st_d.ext_src = pwdata[lvdc_pkg::CTRL_EXT_BIT];
                    st_d.reset_mode_select = pwdata[lvdc_pkg::CTRL_MODE_BIT];
                    st_d.lowvolt_irq_mask = pwdata[lvdc_pkg::CTRL_MASK_BIT];
                end
                // Upper bits are not stored; software keeps them zero.
                lvdc_pkg::ADDR_LEVEL: st_d.level_select_reg = pwdata[3:0];
                lvdc_pkg::ADDR_STATUS: begin
                    st_d.status = st_q.status & ~pwdata[1:0];
                    st_d.lowvolt_irq_flag = st_q.lowvolt_irq_flag & ~pwdata[lvdc_pkg::ST_DETECT_BIT];
                    if (ev_irq) begin
                        st_d.lowvolt_irq_flag = 1'b1;
                    end
                end
                lvdc_pkg::ADDR_MASK: st_d.irq_en = pwdata[1:0];
                default: begin
                end
            endcase
        end

        // Sticky status; a set in the clearing cycle wins.
        if (ev_irq) begin
            st_d.status[lvdc_pkg::ST_DETECT_BIT] = 1'b1;
        end
        if (ev_rst) begin
            st_d.status[lvdc_pkg::ST_RESET_BIT] = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.state <= lvdc_pkg::LVDC_OFF;
            st_q.detector_enable <= lvdc_pkg::CTRL_RST[lvdc_pkg::CTRL_EN_BIT];
            st_q.reset_mode_select <= lvdc_pkg::CTRL_RST[lvdc_pkg::CTRL_MODE_BIT];
            st_q.lowvolt_irq_mask <= lvdc_pkg::CTRL_RST[lvdc_pkg::CTRL_MASK_BIT];
            st_q.level_select_reg <= lvdc_pkg::LEVEL_RST;
            st_q.irq_en <= lvdc_pkg::MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // APB answers; no address is refused, unmapped ones read zero.
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_q.rdata;
    // Comparator control; external source forces the fixed threshold code.
    assign cmp_enable = st_q.detector_enable;
    assign ext_sense_sel = st_q.ext_src;
    assign cmp_level = st_q.ext_src ? lvdc_pkg::EXT_FIXED_LEVEL : st_q.level_select_reg;
    assign lowvolt_irq_request = st_q.irq_pulse;
    assign internal_reset_req = st_q.rst_out;
    assign irq = |(st_q.status & st_q.irq_en);
endmodule : lvdc_top

/* dv/lvdc_sva.sv */
`timescale 1ns/1ps
// Port-level checker; helper state mirrors the last control write.
module lvdc_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus and comparator
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic below_threshold,
    input wire logic cmp_enable,
    input wire logic ext_sense_sel,
    input wire logic [3:0] cmp_level,
    // Events
    input wire logic lowvolt_irq_request,
    input wire logic internal_reset_req
);
    logic mode_q;
    logic mask_q;
    logic [3:0] run_q;
    wire wr_ctrl = psel && penable && pwrite && paddr == lvdc_pkg::ADDR_CTRL;
    // The run counter saturates, so crossing checks skip the settle window.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
            mask_q <= 1'b1;
            run_q <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                mode_q <= pwdata[1];
                mask_q <= pwdata[0];
            end
            run_q <= !cmp_enable ? 4'h0 : (run_q == 4'hf ? run_q : run_q + 4'h1);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ext_level: assert property (ext_sense_sel |-> cmp_level == lvdc_pkg::EXT_FIXED_LEVEL)
        else $error("external source without fixed level");
    // The request is gated by the mask in force before the write, so only an unmasked stop is checked.
    a_stop_low: assert property (wr_ctrl && pwdata[7:0] == 8'h00 && !mode_q && !mask_q && cmp_enable
        && below_threshold |-> ##[1:3] lowvolt_irq_request) else $error("stop while low gave no request");
    // Two quiet samples after the write rule out a genuine new crossing in the checked cycles.
    a_mode_quiet: assert property (wr_ctrl && pwdata[1] && !below_threshold ##1 !below_threshold [*2]
        |-> !internal_reset_req [*2]) else $error("reset on mode write while high");
    a_one_outcome: assert property (internal_reset_req |-> !lowvolt_irq_request)
        else $error("reset and interrupt together");
    a_rise_reset: assert property ($rose(below_threshold) && run_q == 4'hf && mode_q
        |-> ##[1:2] internal_reset_req) else $error("crossing gave no reset");
    a_rise_irq: assert property ($rose(below_threshold) && run_q == 4'hf && !mode_q && !mask_q
        |-> ##[1:2] lowvolt_irq_request) else $error("crossing gave no request");
    a_enable_low: assert property (($rose(cmp_enable) && !mode_q && !mask_q) ##0 below_threshold [*4]
        |-> ##[0:6] lowvolt_irq_request) else $error("enable while low gave no request");
    c_irq: cover property (lowvolt_irq_request);
    c_rst: cover property (internal_reset_req);
    c_ext: cover property (ext_sense_sel && cmp_enable);
endmodule : lvdc_sva
bind lvdc_top lvdc_sva u_sva (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .below_threshold(below_threshold),
    .cmp_enable(cmp_enable),
    .ext_sense_sel(ext_sense_sel),
    .cmp_level(cmp_level),
    .lowvolt_irq_request(lowvolt_irq_request),
    .internal_reset_req(internal_reset_req)
);

/* dv/lvdc_cmp_model.sv */
`timescale 1ns/1ps
// Comparator stand-in; voltages are codes, and a stopped comparator reports nothing.
module lvdc_cmp_model (
    // Control from the block
    input wire logic cmp_enable,
    input wire logic ext_sense_sel,
    input wire logic [3:0] cmp_level,
    // Analog levels as codes
    input wire logic [3:0] vdd_code,
    input wire logic [3:0] ext_code,
    // Result
    output logic below_threshold
);
    // The level input is trusted as is, so a wrong external threshold shows as a missed event.
    assign below_threshold = cmp_enable && ((ext_sense_sel ? ext_code : vdd_code) < cmp_level);
endmodule : lvdc_cmp_model

/* dv/lvdc_tb_top.sv */
`timescale 1ns/1ps
module lvdc_tb_top;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, below_threshold;
    logic cmp_enable, ext_sense_sel, lowvolt_irq_request, internal_reset_req, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] cmp_level, vdd_code, ext_code;
    int fails, check_count, cyc, n_irq, n_rst;
    lvdc_top u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .below_threshold(below_threshold),
        .cmp_enable(cmp_enable),
        .ext_sense_sel(ext_sense_sel),
        .cmp_level(cmp_level),
        .lowvolt_irq_request(lowvolt_irq_request),
        .internal_reset_req(internal_reset_req),
        .irq(irq)
    );
    lvdc_cmp_model u_cmp (
        .cmp_enable(cmp_enable),
        .ext_sense_sel(ext_sense_sel),
        .cmp_level(cmp_level),
        .vdd_code(vdd_code),
        .ext_code(ext_code),
        .below_threshold(below_threshold)
    );
    // Clock source.
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Event pulses stand one cycle, so each is counted once; the cycle ceiling cuts a hang.
    always @(posedge core_clk) begin
        cyc++;
        n_irq += int'(lowvolt_irq_request === 1'b1);
        n_rst += int'(internal_reset_req === 1'b1);
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    // One APB transfer; a spare edge before setup keeps back-to-back calls clean.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check(32'(pslverr), 32'h0);
    endtask : rdc
    task automatic setv(input logic [3:0] v, input int n);
        @(posedge core_clk);
        vdd_code <= v;
        repeat (n) @(posedge core_clk);
    endtask : setv
    initial begin
        {psel, penable, pwrite, rst_n} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        vdd_code = 4'hf;
        ext_code = 4'hf;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(lvdc_pkg::ADDR_CTRL, 32'h1);
        rdc(lvdc_pkg::ADDR_LEVEL, 32'h0);
        rdc(lvdc_pkg::ADDR_STATUS, 32'h0);
        rdc(lvdc_pkg::ADDR_MASK, 32'h0);
        apb(1'b1, 8'h14, 32'hff);
        rdc(8'h14, 32'h0);
        $display("reset values done");
        apb(1'b1, lvdc_pkg::ADDR_LEVEL, 32'h4);
        apb(1'b1, lvdc_pkg::ADDR_MASK, 32'h3);
        setv(4'h0, 0);
        apb(1'b1, lvdc_pkg::ADDR_CTRL, 32'h80);
        setv(4'h0, 12);
        check(n_irq, 1);
        check(32'(irq), 1);
        check(32'(cmp_enable), 32'h1);
        check(32'(cmp_level), 32'h4);
        rdc(lvdc_pkg::ADDR_STATUS, 32'h1);
        apb(1'b0, lvdc_pkg::ADDR_MON, 32'h0);
        check(rd & 32'h2, 32'h2);
        apb(1'b1, lvdc_pkg::ADDR_STATUS, 32'h1);
        setv(4'h0, 1);
        check(32'(irq), 0);
        $display("enable while low done");
        for (int i = 0; i < 3; i++) begin
            setv(4'hf, 3);
            setv(4'h0, 3);
        end
        check(n_irq, 4);
        apb(1'b1, lvdc_pkg::ADDR_STATUS, 32'h3);
        apb(1'b1, lvdc_pkg::ADDR_CTRL, 32'h0);
        setv(4'h0, 3);
        check(32'(cmp_enable), 32'h0);
        check(n_irq, 5);
        rdc(lvdc_pkg::ADDR_STATUS, 32'h1);
        apb(1'b1, lvdc_pkg::ADDR_STATUS, 32'h3);
        $display("crossings and stop done");
        setv(4'hf, 0);
        apb(1'b1, lvdc_pkg::ADDR_CTRL, 32'h82);
        // Long enough that the checker's run counter saturates before the crossing.
        setv(4'hf, 16);
        check(n_rst, 0);
        setv(4'h0, 3);
        check(n_rst, 1);
        check(n_irq, 5);
        rdc(lvdc_pkg::ADDR_STATUS, 32'h2);
        // The reset request is answered by a block reset, so no write happens while enabled.
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(lvdc_pkg::ADDR_CTRL, 32'h1);
        $display("reset mode done");
        @(posedge core_clk);
        ext_code <= 4'h8;
        apb(1'b1, lvdc_pkg::ADDR_CTRL, 32'h84);
        setv(4'h0, 12);
        check(32'(cmp_level), 32'(lvdc_pkg::EXT_FIXED_LEVEL));
        check(32'(ext_sense_sel), 32'h1);
        check(n_irq, 6);
        $display("external source done");
        final_report();
    end
endmodule : lvdc_tb_top
